// ===== design/dmt_consts.svh
`ifndef DMT_CONSTS_SVH
`define DMT_CONSTS_SVH

// ------------------------------------------------------------
// Register map: word indices, byte address is four times these.
// ------------------------------------------------------------
`define DMT_IDX_CTRL 16'hffc8
`define DMT_IDX_FLAGS 16'hffc9
`define DMT_IDX_CONST_A 16'hffca
`define DMT_IDX_CONST_B 16'hffcb
`define DMT_IDX_COUNT 16'hffcc
`define DMT_CH_STRIDE 16'h0008
`define DMT_NUM_REGS 16'h0005
`define DMT_NCH 2

// ------------------------------------------------------------
// Field positions and reset values.
// ------------------------------------------------------------
`define DMT_IE_B_BIT 7
`define DMT_IE_A_BIT 6
`define DMT_IE_W_BIT 5
`define DMT_CLR_MSB 4
`define DMT_CLR_LSB 3
`define DMT_CKS_MSB 2
`define DMT_FLAG_MSB 7
`define DMT_FLAG_LSB 5
`define DMT_OSEL_MSB 3
`define DMT_RST_CTRL 8'h00
`define DMT_RST_FLAGS 8'h10
`define DMT_RST_CONST 8'hff
`define DMT_RST_COUNT 8'h00
`define DMT_COUNT_TOP 8'hff

// ------------------------------------------------------------
// Prescaler taps: a tap falls when these low bits are all ones.
// ------------------------------------------------------------
`define DMT_DIV8_MASK 10'h007
`define DMT_DIV64_MASK 10'h03f
`define DMT_DIV1024_MASK 10'h3ff

`endif

// ===== design/dmt_pkg.sv
`include "dmt_consts.svh"
package dmt_pkg;

  // ----------------------------------------------------------
  // Mode encodings, in register code order.
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    CKS_STOP, CKS_DIV8, CKS_DIV64, CKS_DIV1024,
    CKS_STOP_ALT, CKS_EXT_RISE, CKS_EXT_FALL, CKS_EXT_BOTH
  } dmt_cks_e;
  typedef enum logic [1:0] {CLR_NONE, CLR_MATCH_A, CLR_MATCH_B, CLR_EXT} dmt_clr_e;
  typedef enum logic [1:0] {OUT_KEEP, OUT_LOW, OUT_HIGH, OUT_TOGGLE} dmt_act_e;

  // ----------------------------------------------------------
  // Bus carriers.
  // ----------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } dmt_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dmt_apb_rsp_s;

  // ----------------------------------------------------------
  // State records.
  // ----------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] flags;
    logic [2:0] armed;
    logic [3:0] osel;
    logic [7:0] ca;
    logic [7:0] cb;
    logic [7:0] cnt;
    logic eqa_d;
    logic eqb_d;
    logic wave;
    logic [2:0] irq;
  } dmt_chan_s;
  typedef struct packed {
    dmt_chan_s [`DMT_NCH-1:0] ch;
    logic [9:0] presc;
    logic rdy;
    logic err;
    logic [7:0] rdata;
  } dmt_state_s;
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
  } dmt_sync_s;

endpackage : dmt_pkg

// ===== design/dmt_pin_sync.sv
`timescale 1ns/10ps
`include "dmt_consts.svh"
module dmt_pin_sync import dmt_pkg::*; (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Raw pins: bit 0 count clock, bit 1 clear input.
  input wire logic [1:0] pins,
  // Edge pulses, one cycle each.
  output logic [1:0] rise,
  output logic [1:0] fall
);

  dmt_sync_s st_ff;
  dmt_sync_s nxt;

  // Three stages: the first is read only by the second, edges come
  // from the last two so a late-settling sample never forms an edge.
  always_comb begin
    nxt = st_ff;
    nxt.s1 = pins;
    nxt.s2 = st_ff.s1;
    nxt.s3 = st_ff.s2;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt;
    end
  end

  // Edge detection on the settled stages.
  assign rise = st_ff.s2 & ~st_ff.s3;
  assign fall = ~st_ff.s2 & st_ff.s3;

endmodule : dmt_pin_sync

// ===== design/dmt_timer_top.sv
`timescale 1ns/10ps
`include "dmt_consts.svh"
module dmt_timer_top import dmt_pkg::*; (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // APB slave.
  input wire dmt_apb_req_s apb_req,
  output dmt_apb_rsp_s apb_rsp,
  // Standby request, level.
  input wire logic standby,
  // Channel 0 pins.
  input wire logic ext_count_clk_ch0,
  input wire logic ext_clear_in_ch0,
  output logic wave_out_ch0,
  // Channel 1 pins.
  input wire logic ext_count_clk_ch1,
  input wire logic ext_clear_in_ch1,
  output logic wave_out_ch1,
  // Interrupt requests, bit index is the channel.
  output logic [1:0] match_a_irq,
  output logic [1:0] match_b_irq,
  output logic [1:0] wrap_irq
);

  localparam dmt_chan_s CH_RST = '{
    ctrl: `DMT_RST_CTRL, flags: 3'h0, armed: 3'h0,
    osel: 4'(`DMT_RST_FLAGS), ca: `DMT_RST_CONST, cb: `DMT_RST_CONST,
    cnt: `DMT_RST_COUNT, eqa_d: 1'b0, eqb_d: 1'b0, wave: 1'b0, irq: 3'h0};

  dmt_state_s st_ff;
  dmt_state_s nxt;

  // ------------------------------------------------------------
  // Bus phase decode.
  // ------------------------------------------------------------
  logic acc;
  logic done;
  logic addr_ok;
  logic [15:0] idx;
  logic [`DMT_NCH-1:0] sel_ch;
  logic [2:0] off [`DMT_NCH];
  logic [`DMT_NCH-1:0] wr_done;
  logic [`DMT_NCH-1:0] rd_take;
  logic [`DMT_NCH-1:0] tick;
  logic [`DMT_NCH-1:0] ext_clr;
  logic [`DMT_NCH-1:0] eq_a;
  logic [`DMT_NCH-1:0] eq_b;
  logic [`DMT_NCH-1:0] ev_a;
  logic [`DMT_NCH-1:0] ev_b;
  logic [1:0] pin_in [`DMT_NCH];
  logic [1:0] pin_rise [`DMT_NCH];
  logic [1:0] pin_fall [`DMT_NCH];
  logic t8;
  logic t64;
  logic t1024;

  // One wait state: the access cycle raises pready, the next edge completes.
  assign acc = apb_req.psel & apb_req.penable;
  assign done = acc & st_ff.rdy;
  assign idx = apb_req.paddr[17:2];
  assign addr_ok = (apb_req.paddr[31:18] == 14'h0000) && (apb_req.paddr[1:0] == 2'h0);

  // Prescaler taps fall when the low bits roll over, giving one-cycle enables.
  assign t8 = (st_ff.presc & `DMT_DIV8_MASK) == `DMT_DIV8_MASK;
  assign t64 = (st_ff.presc & `DMT_DIV64_MASK) == `DMT_DIV64_MASK;
  assign t1024 = (st_ff.presc & `DMT_DIV1024_MASK) == `DMT_DIV1024_MASK;

  assign pin_in[0] = {ext_clear_in_ch0, ext_count_clk_ch0};
  assign pin_in[1] = {ext_clear_in_ch1, ext_count_clk_ch1};

  // Picks the count pulse for one channel from its clock-select code.
  function automatic logic pick_tick(input logic [2:0] code, input logic r, input logic f,
                                     input logic p8, input logic p64, input logic p1024);
    logic t;
    t = 1'b0;
    unique case (dmt_cks_e'(code))
      CKS_STOP, CKS_STOP_ALT: t = 1'b0;
      CKS_DIV8: t = p8;
      CKS_DIV64: t = p64;
      CKS_DIV1024: t = p1024;
      CKS_EXT_RISE: t = r;
      CKS_EXT_FALL: t = f;
      CKS_EXT_BOTH: t = r | f;
    endcase
    return t;
  endfunction : pick_tick

  // Applies one action code to the output level.
  function automatic logic apply_act(input logic lvl, input logic [1:0] act);
    logic v;
    v = lvl;
    unique case (dmt_act_e'(act))
      OUT_KEEP: v = lvl;
      OUT_LOW: v = 1'b0;
      OUT_HIGH: v = 1'b1;
      OUT_TOGGLE: v = ~lvl;
    endcase
    return v;
  endfunction : apply_act

  // ------------------------------------------------------------
  // Per-channel decode, pins and compare.
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `DMT_NCH; g = g + 1) begin : gch
      logic [15:0] rel;
      assign rel = idx - 16'(`DMT_IDX_CTRL + g * `DMT_CH_STRIDE);
      assign sel_ch[g] = addr_ok && (rel < `DMT_NUM_REGS);
      assign off[g] = rel[2:0];
      assign wr_done[g] = done & apb_req.pwrite & sel_ch[g];
      assign rd_take[g] = acc & ~st_ff.rdy & ~apb_req.pwrite & sel_ch[g];

      dmt_pin_sync i_dmt_pin_sync (
        .mclk(mclk),
        .rstn(rstn),
        .pins(pin_in[g]),
        .rise(pin_rise[g]),
        .fall(pin_fall[g])
      );

      assign tick[g] = pick_tick(st_ff.ch[g].ctrl[`DMT_CKS_MSB:0], pin_rise[g][0],
                                 pin_fall[g][0], t8, t64, t1024);
      assign ext_clr[g] = pin_rise[g][1];
      // Continuous compare; a match is an event on the first equal cycle, unless a write to that constant completes then.
      assign eq_a[g] = st_ff.ch[g].cnt == st_ff.ch[g].ca;
      assign eq_b[g] = st_ff.ch[g].cnt == st_ff.ch[g].cb;
      assign ev_a[g] = eq_a[g] & ~st_ff.ch[g].eqa_d &
                       ~(wr_done[g] && off[g] == 3'h2);
      assign ev_b[g] = eq_b[g] & ~st_ff.ch[g].eqb_d &
                       ~(wr_done[g] && off[g] == 3'h3);
    end
  endgenerate

  // ------------------------------------------------------------
  // Next-state logic for bus, prescaler and both channels.
  // ------------------------------------------------------------
  always_comb begin
    logic do_clr;
    logic [7:0] rd;
    logic [2:0] set;
    logic [2:0] clr;
    logic [7:0] wd;
    do_clr = 1'b0;
    rd = 8'h00;
    set = 3'h0;
    clr = 3'h0;
    wd = apb_req.pwdata[7:0];
    nxt = st_ff;
    nxt.presc = st_ff.presc + 10'h001;
    nxt.rdy = acc & ~st_ff.rdy;
    for (int i = 0; i < `DMT_NCH; i++) begin
      // Read data is latched when pready rises and held through completion.
      if (sel_ch[i]) begin
        case (off[i])
          3'h0: rd = st_ff.ch[i].ctrl;
          3'h1: rd = {st_ff.ch[i].flags, 1'b1, st_ff.ch[i].osel};
          3'h2: rd = st_ff.ch[i].ca;
          3'h3: rd = st_ff.ch[i].cb;
          3'h4: rd = st_ff.ch[i].cnt;
          default: rd = 8'h00;
        endcase
      end
      // Clear has priority over a counter write, a write over a count pulse.
      unique case (dmt_clr_e'(st_ff.ch[i].ctrl[`DMT_CLR_MSB:`DMT_CLR_LSB]))
        CLR_NONE: do_clr = 1'b0;
        CLR_MATCH_A: do_clr = tick[i] & eq_a[i];
        CLR_MATCH_B: do_clr = tick[i] & eq_b[i];
        CLR_EXT: do_clr = ext_clr[i];
      endcase
      if (do_clr) begin
        nxt.ch[i].cnt = 8'h00;
      end else if (wr_done[i] && off[i] == 3'h4) begin
        nxt.ch[i].cnt = wd;
      end else if (tick[i]) begin
        nxt.ch[i].cnt = st_ff.ch[i].cnt + 8'h01;
      end
      set = {ev_b[i], ev_a[i], 1'b0};
      set[0] = tick[i] & ~do_clr & ~(wr_done[i] && off[i] == 3'h4) &
               (st_ff.ch[i].cnt == `DMT_COUNT_TOP);
      // Register writes; the control field layout is fixed by bit position.
      clr = 3'h0;
      if (wr_done[i]) begin
        case (off[i])
          3'h0: nxt.ch[i].ctrl = wd;
          3'h1: begin
            clr = ~wd[`DMT_FLAG_MSB:`DMT_FLAG_LSB] & st_ff.ch[i].armed;
            nxt.ch[i].osel = wd[`DMT_OSEL_MSB:0];
            nxt.ch[i].armed = 3'h0;
          end
          3'h2: nxt.ch[i].ca = wd;
          3'h3: nxt.ch[i].cb = wd;
          default: nxt.ch[i].ctrl = st_ff.ch[i].ctrl;
        endcase
      end
      // A read that sees a flag set arms its later clear.
      if (rd_take[i] && off[i] == 3'h1) begin
        nxt.ch[i].armed = st_ff.ch[i].flags;
      end
      // A new event in the clearing cycle survives the clear.
      nxt.ch[i].flags = (st_ff.ch[i].flags & ~clr) | set;
      nxt.ch[i].eqa_d = eq_a[i];
      nxt.ch[i].eqb_d = eq_b[i];
      // Both events in one cycle: toggle beats high, high beats low.
      if (ev_a[i] && ev_b[i]) begin
        if (st_ff.ch[i].osel[3:2] == 2'h3 || st_ff.ch[i].osel[1:0] == 2'h3) begin
          nxt.ch[i].wave = ~st_ff.ch[i].wave;
        end else if (st_ff.ch[i].osel[3:2] == 2'h2 || st_ff.ch[i].osel[1:0] == 2'h2) begin
          nxt.ch[i].wave = 1'b1;
        end else if (st_ff.ch[i].osel != 4'h0) begin
          nxt.ch[i].wave = 1'b0;
        end
      end else if (ev_a[i]) begin
        nxt.ch[i].wave = apply_act(st_ff.ch[i].wave, st_ff.ch[i].osel[1:0]);
      end else if (ev_b[i]) begin
        nxt.ch[i].wave = apply_act(st_ff.ch[i].wave, st_ff.ch[i].osel[3:2]);
      end
      // Standby holds the whole channel at its reset image.
      if (standby) begin
        nxt.ch[i] = CH_RST;
      end
      // Requests follow flag and enable; separate lines per source.
      nxt.ch[i].irq = nxt.ch[i].flags & {nxt.ch[i].ctrl[`DMT_IE_B_BIT],
                                         nxt.ch[i].ctrl[`DMT_IE_A_BIT],
                                         nxt.ch[i].ctrl[`DMT_IE_W_BIT]};
    end
    // The error flag stands only in the completion cycle, so pslverr needs no gate.
    nxt.err = 1'b0;
    if (acc && !st_ff.rdy) begin
      nxt.rdata = rd;
      nxt.err = ~(|sel_ch);
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_ff <= '{ch: {`DMT_NCH{CH_RST}}, presc: 10'h000, rdy: 1'b0, err: 1'b0, rdata: 8'h00};
    end else begin
      st_ff <= nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all taken from the state register.
  // ------------------------------------------------------------
  assign apb_rsp.prdata = {24'h000000, st_ff.rdata};
  assign apb_rsp.pready = st_ff.rdy;
  assign apb_rsp.pslverr = st_ff.err;
  assign wave_out_ch0 = st_ff.ch[0].wave;
  assign wave_out_ch1 = st_ff.ch[1].wave;
  assign match_a_irq = {st_ff.ch[1].irq[1], st_ff.ch[0].irq[1]};
  assign match_b_irq = {st_ff.ch[1].irq[2], st_ff.ch[0].irq[2]};
  assign wrap_irq = {st_ff.ch[1].irq[0], st_ff.ch[0].irq[0]};

  // ------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence
  AST_APB_ONE_WAIT: assert property (s_setup ##1 s_access |-> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("pready not raised after one wait state");
  AST_ERR_WITH_READY: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr raised outside a completion cycle");

  generate
    for (g = 0; g < `DMT_NCH; g = g + 1) begin : gchk
      AST_STOP_HOLDS: assert property (
        st_ff.ch[g].ctrl[1:0] == 2'h0 && !standby && !wr_done[g] && !ext_clr[g]
        |=> st_ff.ch[g].cnt == $past(st_ff.ch[g].cnt))
        else $error("stopped counter moved");
      AST_TICK_INCR: assert property (
        tick[g] && st_ff.ch[g].ctrl[4:3] == 2'h0 && !standby && !wr_done[g]
        |=> st_ff.ch[g].cnt == 8'($past(st_ff.ch[g].cnt) + 8'h01))
        else $error("counter did not step by one");
      AST_WRAP_SETS: assert property (
        tick[g] && st_ff.ch[g].cnt == 8'hff && st_ff.ch[g].ctrl[4:3] == 2'h0
        && !standby && !wr_done[g] |=> st_ff.ch[g].flags[0] && st_ff.ch[g].cnt == 8'h00)
        else $error("wrap flag missing");
      AST_MATCH_A_SETS: assert property (
        ev_a[g] && !standby |=> st_ff.ch[g].flags[1])
        else $error("match A flag missing");
      AST_EXT_CLEAR: assert property (
        st_ff.ch[g].ctrl[4:3] == 2'h3 && ext_clr[g] && !standby |=> st_ff.ch[g].cnt == 8'h00)
        else $error("external clear ignored");
      AST_ONES_KEEP_FLAGS: assert property (
        wr_done[g] && off[g] == 3'h1 && apb_req.pwdata[7:5] == 3'h7 && !standby && !tick[g]
        && !ev_a[g] && !ev_b[g]
        |=> st_ff.ch[g].flags == $past(st_ff.ch[g].flags))
        else $error("writing ones changed flags");
      AST_IRQ_A: assert property (
        $rose(st_ff.ch[g].flags[1]) && st_ff.ch[g].ctrl[6] |-> st_ff.ch[g].irq[1] ##1
        (st_ff.ch[g].irq[1] == (st_ff.ch[g].flags[1] && st_ff.ch[g].ctrl[6])))
        else $error("match A request wrong");
      AST_STANDBY_IMAGE: assert property (
        standby |=> st_ff.ch[g].cnt == 8'h00 && st_ff.ch[g].ca == 8'hff
        && st_ff.ch[g].cb == 8'hff && st_ff.ch[g].ctrl == 8'h00)
        else $error("standby image wrong");
      AST_MATCH_B_SETS: assert property (
        ev_b[g] && !standby |=> st_ff.ch[g].flags[2])
        else $error("match B flag missing");
      AST_CLEAR_ON_B: assert property (
        st_ff.ch[g].ctrl[4:3] == 2'h2 && tick[g] && eq_b[g] && !standby
        |=> st_ff.ch[g].cnt == 8'h00)
        else $error("clear on match B ignored");
      AST_CONST_WRITE_MASKS: assert property (
        wr_done[g] && off[g] == 3'h2 && !st_ff.ch[g].flags[1] && !standby
        |=> !st_ff.ch[g].flags[1])
        else $error("match A seen during constant write");
      // Requests are checked on the output pins, not on internal state alone.
      AST_IRQ_B_LEVEL: assert property (
        match_b_irq[g] == (st_ff.ch[g].flags[2] && st_ff.ch[g].ctrl[`DMT_IE_B_BIT]))
        else $error("match B request does not follow its flag");
      AST_IRQ_W_LEVEL: assert property (
        wrap_irq[g] == (st_ff.ch[g].flags[0] && st_ff.ch[g].ctrl[`DMT_IE_W_BIT]))
        else $error("wrap request does not follow its flag");
      // Output actions, one event at a time; coincident events follow the priority.
      AST_WAVE_A_HIGH: assert property (
        ev_a[g] && !ev_b[g] && st_ff.ch[g].osel[1:0] == 2'h2 && !standby |=> st_ff.ch[g].wave)
        else $error("match A did not drive output high");
      AST_WAVE_B_LOW: assert property (
        ev_b[g] && !ev_a[g] && st_ff.ch[g].osel[3:2] == 2'h1 && !standby |=> !st_ff.ch[g].wave)
        else $error("match B did not drive output low");
      AST_WAVE_TOGGLE: assert property (
        ev_a[g] && !ev_b[g] && st_ff.ch[g].osel[1:0] == 2'h3 && !standby
        |=> st_ff.ch[g].wave != $past(st_ff.ch[g].wave))
        else $error("match A did not toggle output");
      // Clearing a flag needs the arming read first.
      AST_ARMED_CLEARS: assert property (
        wr_done[g] && off[g] == 3'h1 && !apb_req.pwdata[6] && st_ff.ch[g].armed[1]
        && !ev_a[g] && !standby |=> !st_ff.ch[g].flags[1])
        else $error("armed flag A not cleared");
      AST_UNARMED_KEEPS: assert property (
        wr_done[g] && off[g] == 3'h1 && !st_ff.ch[g].armed[1] && st_ff.ch[g].flags[1]
        && !standby |=> st_ff.ch[g].flags[1])
        else $error("flag A cleared without a read");
    end
  endgenerate

endmodule : dmt_timer_top

// ===== verif/dmt_pin_model.sv
`timescale 1ns/10ps
// --------------------
// Far side: pin driver and waveform load.
// --------------------
module dmt_pin_model (
  // Clock.
  input wire logic mclk,
  // Waveform outputs, seen as the load.
  input wire logic [1:0] wave,
  // Pins toward the timer, bit index is the channel.
  output logic [1:0] cnt_clk,
  output logic [1:0] clr_in
);
  // Pins rest low between commanded pulses.
  initial begin
    cnt_clk = 2'b00;
    clr_in = 2'b00;
  end

  // One pulse: four cycles high, then ten cycles low before the next.
  // This keeps each level well past the three-flop sampler depth.
  task automatic pulse(input int ch, input logic clr);
    @(posedge mclk);
    if (clr) clr_in[ch] <= 1'b1;
    else cnt_clk[ch] <= 1'b1;
    repeat (4) @(posedge mclk);
    clr_in[ch] <= 1'b0;
    cnt_clk[ch] <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask : pulse
endmodule : dmt_pin_model

// ===== verif/dmt_timer_top_tb.sv
`timescale 1ns/10ps
`include "dmt_consts.svh"
module dmt_timer_top_tb import dmt_pkg::*;;
  // --------------------
  // Signals and tables.
  // --------------------
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic standby = 1'b0;
  dmt_apb_req_s req = '0;
  dmt_apb_rsp_s rsp;
  logic [1:0] cclk, clr, wave, irq_a, irq_b, irq_w;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  logic [15:0] ridx [5] = '{`DMT_IDX_CTRL, `DMT_IDX_FLAGS, `DMT_IDX_CONST_A,
                            `DMT_IDX_CONST_B, `DMT_IDX_COUNT};
  logic [7:0] rrst [5] = '{8'h00, 8'h10, 8'hff, 8'hff, 8'h00};
  logic [7:0] pat [5] = '{8'ha5, 8'h0f, 8'h3c, 8'hc3, 8'h5a};
  logic [7:0] bk [5] = '{8'ha5, 8'h1f, 8'h3c, 8'hc3, 8'h5a};

  // Free-running 125 MHz clock.
  always #4 mclk = ~mclk;

  dmt_timer_top i_dmt_timer_top (.mclk(mclk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
    .standby(standby), .ext_count_clk_ch0(cclk[0]), .ext_clear_in_ch0(clr[0]),
    .wave_out_ch0(wave[0]), .ext_count_clk_ch1(cclk[1]), .ext_clear_in_ch1(clr[1]),
    .wave_out_ch1(wave[1]), .match_a_irq(irq_a), .match_b_irq(irq_b), .wrap_irq(irq_w));
  dmt_pin_model i_dmt_pin_model (.mclk(mclk), .wave(wave), .cnt_clk(cclk), .clr_in(clr));

  // --------------------
  // Bus and compare helpers.
  // --------------------
  function automatic logic [31:0] adr(input int ch, input logic [15:0] idx);
    logic [15:0] i;
    i = idx + 16'(ch) * `DMT_CH_STRIDE;
    return {14'h0, i, 2'b00};
  endfunction : adr

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One transfer; an idle edge leads it so psel never changes twice in a step.
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic e);
    @(posedge mclk);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= {24'h0, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    // Sample pready at each rising edge; only the watchdog ends a hang.
    do begin
      @(posedge mclk);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata[7:0];
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input int ch, input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    apb(1'b1, adr(ch, idx), d, q, e);
  endtask : wr

  task automatic rdc(input string what, input int ch, input logic [15:0] idx,
                     input logic [7:0] exp);
    logic [7:0] q;
    logic e;
    apb(1'b0, adr(ch, idx), 8'h00, q, e);
    chk(what, q, exp);
  endtask : rdc

  // --------------------
  // Scenarios.
  // --------------------
  // Reset image, readback, isolation and refused addresses.
  task automatic t_regs();
    logic [7:0] q;
    logic e;
    for (int ch = 0; ch < 2; ch++) begin
      for (int r = 0; r < 5; r++) rdc("reset value", ch, ridx[r], rrst[r]);
    end
    for (int r = 0; r < 5; r++) wr(0, ridx[r], pat[r]);
    for (int r = 0; r < 5; r++) rdc("readback", 0, ridx[r], bk[r]);
    for (int r = 0; r < 5; r++) rdc("other channel", 1, ridx[r], rrst[r]);
    apb(1'b0, adr(0, 16'hffcd), 8'h00, q, e);
    chk("unmapped err", {7'h0, e}, 8'h01);
    chk("unmapped data", q, 8'h00);
    apb(1'b1, adr(0, `DMT_IDX_CTRL) | 32'h1, 8'hff, q, e);
    chk("misaligned err", {7'h0, e}, 8'h01);
    rdc("ctrl kept", 0, `DMT_IDX_CTRL, 8'ha5);
  endtask : t_regs

  // Standby must put the written channel back to its reset image.
  task automatic t_standby();
    @(posedge mclk);
    standby <= 1'b1;
    repeat (3) @(posedge mclk);
    standby <= 1'b0;
    for (int r = 0; r < 5; r++) rdc("standby value", 0, ridx[r], rrst[r]);
  endtask : t_standby

  // Internal sources; the bus latency blurs the window, so allow one count.
  task automatic t_presc();
    logic [7:0] q;
    logic e;
    int div;
    for (int c = 0; c < 5; c++) begin
      div = (c == 1) ? 8 : (c == 2) ? 64 : (c == 3) ? 1024 : 0;
      wr(0, `DMT_IDX_COUNT, 8'h00);
      wr(0, `DMT_IDX_CTRL, 8'(c));
      repeat (div != 0 ? div * 10 : 64) @(posedge mclk);
      wr(0, `DMT_IDX_CTRL, 8'h00);
      apb(1'b0, adr(0, `DMT_IDX_COUNT), 8'h00, q, e);
      if (div == 0) chk("stopped count", q, 8'h00);
      else chk("divided count", 8'(q >= 9 && q <= 11), 8'h01);
    end
  endtask : t_presc

  // Wrap through all ones; flags clear only after read then write zero.
  task automatic t_wrap();
    wr(0, `DMT_IDX_CTRL, 8'h21);
    wr(0, `DMT_IDX_COUNT, 8'hfd);
    repeat (40) @(posedge mclk);
    wr(0, `DMT_IDX_CTRL, 8'h20);
    chk("wrap irq", {7'h0, irq_w[0]}, 8'h01);
    chk("masked irqs", {6'h0, irq_a[0], irq_b[0]}, 8'h00);
    wr(0, `DMT_IDX_FLAGS, 8'he0);
    wr(0, `DMT_IDX_FLAGS, 8'h00);
    rdc("flags kept", 0, `DMT_IDX_FLAGS, 8'hf0);
    wr(0, `DMT_IDX_FLAGS, 8'h00);
    rdc("flags cleared", 0, `DMT_IDX_FLAGS, 8'h10);
    chk("wrap irq low", {7'h0, irq_w[0]}, 8'h00);
    wr(0, `DMT_IDX_CTRL, 8'h00);
  endtask : t_wrap

  // Channel 1 on its external pins: matches, actions, clears, edge codes.
  task automatic t_ext();
    wr(1, `DMT_IDX_CONST_A, 8'h02);
    wr(1, `DMT_IDX_CONST_B, 8'h04);
    wr(1, `DMT_IDX_FLAGS, 8'h06);
    wr(1, `DMT_IDX_CTRL, 8'hd5);
    repeat (2) i_dmt_pin_model.pulse(1, 1'b0);
    rdc("ext count", 1, `DMT_IDX_COUNT, 8'h02);
    chk("wave on a", {7'h0, wave[1]}, 8'h01);
    chk("irq a only", {5'h0, irq_w[1], irq_a[1], irq_b[1]}, 8'h02);
    repeat (2) i_dmt_pin_model.pulse(1, 1'b0);
    rdc("count at b", 1, `DMT_IDX_COUNT, 8'h04);
    chk("wave on b", {7'h0, wave[1]}, 8'h00);
    chk("irq b", {7'h0, irq_b[1]}, 8'h01);
    i_dmt_pin_model.pulse(1, 1'b0);
    rdc("clear on b", 1, `DMT_IDX_COUNT, 8'h00);
    chk("ch0 quiet", {6'h0, wave[0], irq_a[0]}, 8'h00);
    wr(1, `DMT_IDX_FLAGS, 8'h03);
    for (int c = 6; c < 8; c++) begin
      wr(1, `DMT_IDX_COUNT, 8'h00);
      wr(1, `DMT_IDX_CTRL, 8'(c));
      repeat (3) i_dmt_pin_model.pulse(1, 1'b0);
      rdc("edge count", 1, `DMT_IDX_COUNT, (c == 7) ? 8'h06 : 8'h03);
      chk("toggle", {7'h0, wave[1]}, (c == 6) ? 8'h01 : 8'h00);
    end
    wr(1, `DMT_IDX_CTRL, 8'h1d);
    wr(1, `DMT_IDX_COUNT, 8'h40);
    i_dmt_pin_model.pulse(1, 1'b1);
    rdc("ext clear", 1, `DMT_IDX_COUNT, 8'h00);
    wr(1, `DMT_IDX_CTRL, 8'h0d);
    repeat (4) i_dmt_pin_model.pulse(1, 1'b0);
    rdc("clear on a", 1, `DMT_IDX_COUNT, 8'h01);
    wr(1, `DMT_IDX_CTRL, 8'h00);
  endtask : t_ext

  // --------------------
  // Verdict, watchdog and main sequence.
  // --------------------
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // The full run needs about 12000 cycles; a hang is cut off well past that.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      close_out();
    end
  end

  // Reset for five cycles, then every scenario in turn.
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_standby();
    t_presc();
    t_wrap();
    t_ext();
    close_out();
  end
endmodule : dmt_timer_top_tb
